// ==== verilog/dmarfc_pkg.sv ====
// dmarfc_pkg: constants and types for the dma remap fault classifier
// assumes a single core clock domain; no other file defines these names
package dmarfc_pkg;

   // fault reason codes
   localparam logic [3:0] FR_NONE         = 4'h0;
   localparam logic [3:0] FR_ROOT_NP      = 4'h1;
   localparam logic [3:0] FR_CTX_NP       = 4'h2;
   localparam logic [3:0] FR_CTX_BADPROG  = 4'h3;
   localparam logic [3:0] FR_ADDR_WIDTH   = 4'h4;
   localparam logic [3:0] FR_WRITE_PERM   = 4'h5;
   localparam logic [3:0] FR_READ_PERM    = 4'h6;
   localparam logic [3:0] FR_PT_FETCH     = 4'h7;
   localparam logic [3:0] FR_RT_FETCH     = 4'h8;
   localparam logic [3:0] FR_CT_FETCH     = 4'h9;
   localparam logic [3:0] FR_ROOT_RSVD    = 4'ha;
   localparam logic [3:0] FR_CTX_RSVD     = 4'hb;
   localparam logic [3:0] FR_PT_RSVD      = 4'hc;

   // completion status: ur for a blocked read, sc for any other answer
   localparam logic [2:0] CPL_SC          = 3'h0;
   localparam logic [2:0] CPL_UR          = 3'h1;

   // apb register byte offsets
   localparam logic [11:0] REG_CTRL       = 12'h000;
   localparam logic [11:0] REG_CAP        = 12'h004;
   localparam logic [11:0] REG_FAULT      = 12'h008;
   localparam logic [11:0] REG_SRCID      = 12'h00c;
   localparam logic [11:0] REG_ADDR_LO    = 12'h010;
   localparam logic [11:0] REG_COUNT      = 12'h014;

   // control field positions and reset values
   localparam int CTRL_EN_BIT             = 0;
   localparam int CTRL_ZLEN_BIT           = 1;
   localparam int CTRL_MAXW_LSB           = 8;
   localparam logic [31:0] CTRL_RST       = 32'h0000_3001;
   // supported domain widths: 39 and 48 bits (one bit each in cap)
   localparam logic [2:0] SGAW_RST        = 3'h3;

   // fault register field positions
   localparam int FLT_VALID_BIT           = 31;
   localparam int FLT_QUAL_BIT            = 30;
   localparam int FLT_REPORT_BIT          = 29;

   typedef enum logic [1:0] {
      DMARFC_IDLE  = 2'b00,
      DMARFC_EVAL  = 2'b01,
      DMARFC_DONE  = 2'b10
   } dmarfc_state_t;

endpackage

// ==== verilog/dmarfc_top.sv ====
// dmarfc_top: classifies each untranslated dma request against the root,
// context and page-table lookup results and blocks faulting requests.
// assumes the walker presents all lookup results together with req_valid,
// and holds them until resp_valid; apb is on the same clock.
`timescale 1ns/100ps

module dmarfc_top
   import dmarfc_pkg::*;
#(
   parameter int ADW = 64
) (
   input  wire logic            core_clk,
   input  wire logic            arst_n,
   // request from the walker
   input  wire logic            req_valid,
   input  wire logic            req_is_write,
   input  wire logic            req_zero_len,
   input  wire logic [ADW-1:0]  req_addr,
   input  wire logic [15:0]     req_src_id,
   input  wire logic            req_behind_pci_bridge,
   input  wire logic [15:0]     req_bridge_id,
   input  wire logic            req_internal_err,
   // root / context / pte lookup results
   input  wire logic            rt_fetch_err,
   input  wire logic            root_present,
   input  wire logic            root_rsvd_nz,
   input  wire logic            ct_fetch_err,
   input  wire logic            ctx_present,
   input  wire logic            ctx_rsvd_nz,
   input  wire logic [2:0]      domain_width_field,
   input  wire logic [1:0]      ctx_trans_type,
   input  wire logic            fault_report_disable,
   input  wire logic            table_root_fetch_err,
   input  wire logic            pt_fetch_err,
   input  wire logic            pte_read,
   input  wire logic            pte_write,
   input  wire logic            pte_rsvd_nz,
   // result
   output logic                 resp_valid,
   output logic                 resp_blocked,
   output logic [3:0]           resp_reason,
   output logic                 resp_qualified,
   output logic                 resp_report,
   output logic [2:0]           resp_cpl_status,
   output logic [15:0]          resp_ctx_src_id,
   output logic                 resp_over_hw_width,
   output logic                 platform_err,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr
);
   import dmarfc_pkg::*;

   typedef struct packed {
      dmarfc_state_t  state;
      logic [31:0]    ctrl;
      logic           blocked;
      logic [3:0]     reason;
      logic           qualified;
      logic           report;
      logic [2:0]     cpl;
      logic [15:0]    src_id;
      logic           over_hw;
      logic           plat_err;
      logic           valid;
      logic [31:0]    last_fault;
      logic [15:0]    last_src;
      logic [31:0]    last_addr;
      logic [31:0]    fault_count;
      logic [31:0]    prdata;
      logic           pready;
      logic           pslverr;
   } dmarfc_regs_t;

   dmarfc_regs_t r_r;
   dmarfc_regs_t r_nxt;
   logic         rst_n;
   // kept out of the state struct: the only state on the raw reset
   logic [1:0]   rst_sync_r;

   // supported domain width code -> width in bits (39 + 9*code)
   function automatic logic [6:0] width_of(input logic [2:0] code);
      width_of = 7'd39 + 7'(9 * code);
   endfunction

   // true when any address bit at or above position w is set
   function automatic logic beyond(input logic [ADW-1:0] a, input logic [6:0] w);
      logic res;
      res = 1'b0;
      for (int i = 0; i < ADW; i++) begin
         if (i >= int'(w) && a[i]) begin
            res = 1'b1;
         end
      end
      beyond = res;
   endfunction

   // reset release through two flops, the first read only by the second
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_comb begin
      logic [6:0] max_w;
      logic [6:0] lim;
      logic       sgaw_ok;
      logic       fault;
      logic [3:0] rsn;
      logic       qual;
      logic       apb_acc;
      max_w   = r_r.ctrl[CTRL_MAXW_LSB +: 7];
      lim     = 7'd0;
      sgaw_ok = 1'b0;
      fault   = 1'b1;
      rsn     = FR_NONE;
      qual    = 1'b0;
      apb_acc = psel && penable;
      r_nxt   = r_r;
      r_nxt.valid  = 1'b0;
      r_nxt.pready = 1'b0;
      r_nxt.pslverr = 1'b0;

      lim = (width_of(domain_width_field) < max_w) ? width_of(domain_width_field) : max_w;
      if (domain_width_field < 3'd3) begin
         sgaw_ok = SGAW_RST[domain_width_field[1:0]];
      end

      // checks in lookup order; the first hit wins
      if (rt_fetch_err) begin
         rsn = FR_RT_FETCH;
      end else if (!root_present) begin
         rsn = FR_ROOT_NP;
      end else if (root_rsvd_nz) begin
         rsn = FR_ROOT_RSVD;
      end else if (ct_fetch_err) begin
         rsn = FR_CT_FETCH;
      end else if (!ctx_present) begin
         rsn = FR_CTX_NP;
      end else if (ctx_rsvd_nz) begin
         rsn = FR_CTX_RSVD;
      end else if (!sgaw_ok || ctx_trans_type != 2'b00 || table_root_fetch_err) begin
         rsn = FR_CTX_BADPROG;
      end else if (beyond(req_addr, lim)) begin
         rsn = FR_ADDR_WIDTH;
      end else if (pt_fetch_err) begin
         rsn = FR_PT_FETCH;
      end else if ((pte_read || pte_write) && pte_rsvd_nz) begin
         rsn = FR_PT_RSVD;
      end else if (req_is_write && !pte_write) begin
         rsn = FR_WRITE_PERM;
      end else if (!req_is_write && !pte_read
                   && !(r_r.ctrl[CTRL_ZLEN_BIT] && req_zero_len && pte_write)) begin
         rsn = FR_READ_PERM;
      end else begin
         fault = 1'b0;
      end
      // root presence, root reserved and root/context table fetch faults are unqualified
      qual = fault && (rsn >= FR_CTX_NP) && (rsn <= FR_PT_FETCH || rsn >= FR_CTX_RSVD)
             && rsn != FR_RT_FETCH;

      case (r_r.state)
         DMARFC_IDLE: begin
            if (req_valid && r_r.ctrl[CTRL_EN_BIT]) begin
               r_nxt.state = DMARFC_EVAL;
            end
         end
         DMARFC_EVAL: begin
            r_nxt.valid    = 1'b1;
            r_nxt.state    = DMARFC_DONE;
            // internal errors are not remapping faults
            r_nxt.plat_err = req_internal_err;
            r_nxt.blocked  = req_internal_err || fault;
            r_nxt.reason   = req_internal_err ? FR_NONE : rsn;
            r_nxt.qualified = !req_internal_err && qual;
            r_nxt.report   = !req_internal_err && fault && (!qual || !fault_report_disable);
            r_nxt.cpl      = (!req_is_write && (fault || req_internal_err)) ? CPL_UR : CPL_SC;
            r_nxt.src_id   = req_behind_pci_bridge ? req_bridge_id : req_src_id;
            r_nxt.over_hw  = beyond(req_addr, max_w);
            if (fault && !req_internal_err) begin
               r_nxt.last_fault  = {1'b1, qual, r_nxt.report, 25'h0, rsn};
               r_nxt.last_src    = r_nxt.src_id;
               r_nxt.last_addr   = req_addr[31:0];
               r_nxt.fault_count = r_r.fault_count + 32'h1;
            end
         end
         DMARFC_DONE: begin
            // one idle cycle so a held request is not evaluated twice
            r_nxt.state = DMARFC_IDLE;
         end
         default: r_nxt.state = DMARFC_IDLE;
      endcase

      // apb: answers in the access cycle's following edge (one wait state)
      if (apb_acc && !r_r.pready) begin
         r_nxt.pready = 1'b1;
         r_nxt.prdata = 32'h0;
         if (paddr == REG_CTRL) begin
            r_nxt.prdata = r_r.ctrl;
         end else if (paddr == REG_CAP) begin
            r_nxt.prdata = {29'h0, SGAW_RST};
         end else if (paddr == REG_FAULT) begin
            r_nxt.prdata = r_r.last_fault;
         end else if (paddr == REG_SRCID) begin
            r_nxt.prdata = {16'h0, r_r.last_src};
         end else if (paddr == REG_ADDR_LO) begin
            r_nxt.prdata = r_r.last_addr;
         end else if (paddr == REG_COUNT) begin
            r_nxt.prdata = r_r.fault_count;
         end else begin
            r_nxt.pslverr = 1'b1;
         end
      end
      // a write lands only at the edge that completes the transfer
      if (apb_acc && r_r.pready && pwrite) begin
         if (paddr == REG_CTRL) begin
            r_nxt.ctrl = {17'h0, pwdata[14:8], 6'h0, pwdata[1:0]};
         end else if (paddr == REG_FAULT) begin
            // write one to valid bit clears; a new fault in this cycle wins
            if (pwdata[FLT_VALID_BIT] && !(r_r.state == DMARFC_EVAL && fault)) begin
               r_nxt.last_fault = 32'h0;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r.state       <= DMARFC_IDLE;
         r_r.ctrl        <= CTRL_RST;
         r_r.blocked     <= 1'b0;
         r_r.reason      <= FR_NONE;
         r_r.qualified   <= 1'b0;
         r_r.report      <= 1'b0;
         r_r.cpl         <= CPL_SC;
         r_r.src_id      <= 16'h0;
         r_r.over_hw     <= 1'b0;
         r_r.plat_err    <= 1'b0;
         r_r.valid       <= 1'b0;
         r_r.last_fault  <= 32'h0;
         r_r.last_src    <= 16'h0;
         r_r.last_addr   <= 32'h0;
         r_r.fault_count <= 32'h0;
         r_r.prdata      <= 32'h0;
         r_r.pready      <= 1'b0;
         r_r.pslverr     <= 1'b0;
      end else begin
         r_r.state       <= r_nxt.state;
         r_r.ctrl        <= r_nxt.ctrl;
         r_r.blocked     <= r_nxt.blocked;
         r_r.reason      <= r_nxt.reason;
         r_r.qualified   <= r_nxt.qualified;
         r_r.report      <= r_nxt.report;
         r_r.cpl         <= r_nxt.cpl;
         r_r.src_id      <= r_nxt.src_id;
         r_r.over_hw     <= r_nxt.over_hw;
         r_r.plat_err    <= r_nxt.plat_err;
         r_r.valid       <= r_nxt.valid;
         r_r.last_fault  <= r_nxt.last_fault;
         r_r.last_src    <= r_nxt.last_src;
         r_r.last_addr   <= r_nxt.last_addr;
         r_r.fault_count <= r_nxt.fault_count;
         r_r.prdata      <= r_nxt.prdata;
         r_r.pready      <= r_nxt.pready;
         r_r.pslverr     <= r_nxt.pslverr;
      end
   end

   assign resp_valid         = r_r.valid;
   assign resp_blocked       = r_r.blocked;
   assign resp_reason        = r_r.reason;
   assign resp_qualified     = r_r.qualified;
   assign resp_report        = r_r.report;
   assign resp_cpl_status    = r_r.cpl;
   assign resp_ctx_src_id    = r_r.src_id;
   assign resp_over_hw_width = r_r.over_hw;
   assign platform_err       = r_r.plat_err;
   assign prdata             = r_r.prdata;
   assign pready             = r_r.pready;
   assign pslverr            = r_r.pslverr;

endmodule

// ==== verification/dmarfc_asserts.sv ====
// dmarfc_asserts: temporal checks on the fault classifier ports
// assumes the walker holds every lookup input until resp_valid
`timescale 1ns/100ps
module dmarfc_asserts
   import dmarfc_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        req_is_write,
   input wire logic        req_internal_err,
   input wire logic        rt_fetch_err,
   input wire logic        root_present,
   input wire logic        req_behind_pci_bridge,
   input wire logic [15:0] req_bridge_id,
   input wire logic        fault_report_disable,
   input wire logic        resp_valid,
   input wire logic        resp_blocked,
   input wire logic [3:0]  resp_reason,
   input wire logic        resp_qualified,
   input wire logic        resp_report,
   input wire logic [2:0]  resp_cpl_status,
   input wire logic [15:0] resp_ctx_src_id,
   input wire logic        platform_err
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_quiet;
      !resp_valid [*2];
   endsequence
   sequence s_plain;
      resp_valid && !req_internal_err;
   endsequence
   // a held request still passes idle and eval before the next answer
   a_one_answer: assert property (resp_valid |=> s_quiet)
      else $error("answer pulse repeated");
   a_fault_blocks: assert property (resp_valid && resp_reason != FR_NONE |-> resp_blocked)
      else $error("fault not blocked");
   a_read_ur: assert property (resp_valid && resp_blocked && !req_is_write && !platform_err
      |-> resp_cpl_status == CPL_UR)
      else $error("blocked read without ur");
   a_qual_code: assert property (resp_valid |-> resp_qualified ==
      (resp_reason inside {[4'h2:4'h7], 4'hb, 4'hc}))
      else $error("qualified flag wrong");
   a_report_gate: assert property (resp_valid |-> resp_report ==
      (resp_reason != FR_NONE && (!resp_qualified || !fault_report_disable)))
      else $error("report flag wrong");
   a_rt_first: assert property (s_plain and rt_fetch_err |-> resp_reason == FR_RT_FETCH)
      else $error("root fetch error not first");
   a_root_np: assert property (s_plain and !rt_fetch_err && !root_present
      |-> resp_reason == FR_ROOT_NP && !resp_qualified)
      else $error("missing root misclassified");
   a_internal_err: assert property (resp_valid && req_internal_err
      |-> platform_err && resp_blocked && resp_reason == FR_NONE)
      else $error("internal error misrouted");
   a_bridge_src: assert property (resp_valid && req_behind_pci_bridge
      |-> resp_ctx_src_id == req_bridge_id)
      else $error("bridge id not used");
endmodule
bind dmarfc_top dmarfc_asserts dmarfc_asserts_i (
   .core_clk(core_clk), .arst_n(arst_n), .req_is_write(req_is_write),
   .req_internal_err(req_internal_err), .rt_fetch_err(rt_fetch_err), .root_present(root_present),
   .req_behind_pci_bridge(req_behind_pci_bridge), .req_bridge_id(req_bridge_id),
   .fault_report_disable(fault_report_disable), .resp_valid(resp_valid), .resp_blocked(resp_blocked),
   .resp_reason(resp_reason), .resp_qualified(resp_qualified), .resp_report(resp_report),
   .resp_cpl_status(resp_cpl_status), .resp_ctx_src_id(resp_ctx_src_id), .platform_err(platform_err)
);

// ==== verification/dmarfc_walker.sv ====
// dmarfc_walker: requester and table walker facing the classifier
// assumes one request at a time; answer sampled at the rising edge
`timescale 1ns/100ps
module dmarfc_walker (
   input  wire logic core_clk,
   input  wire logic resp_valid,
   output logic      req_valid = 1'b0,
   output logic [116:0] req_bus = '0
);
   // lookup results hold until answered or for lim edges, whatever the source id
   task automatic send(input logic [116:0] s, input int stall, input int lim, output bit ok);
      ok = 1'b0;
      repeat (stall + 1) @(posedge core_clk);
      req_bus   <= s;
      req_valid <= 1'b1;
      repeat (lim) begin
         @(posedge core_clk);
         if (resp_valid === 1'b1) begin
            ok = 1'b1;
            break;
         end
      end
      req_valid <= 1'b0;
      // released lines must not keep showing the old request
      req_bus   <= ~s;
   endtask
endmodule

// ==== verification/dmarfc_tb_top.sv ====
// dmarfc_tb_top: self-checking bench for the fault classifier
// assumes walker and checker compiled first; apb on core_clk
`timescale 1ns/100ps
module dmarfc_tb_top;
   import dmarfc_pkg::*;
   logic         core_clk = 1'b0;
   logic         arst_n = 1'b0;
   logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]  paddr = '0;
   logic [31:0]  pwdata = '0, prdata, rs = 32'h698d;
   logic         pready, pslverr, req_valid, resp_valid, resp_blocked, resp_qualified;
   logic         resp_report, platform_err, resp_over_hw_width;
   logic [3:0]   resp_reason;
   logic [2:0]   resp_cpl_status;
   logic [15:0]  resp_ctx_src_id, lsrc;
   logic [116:0] b;
   logic [31:0]  laddr;
   int           errors = 0, checks = 0, max_w = 48, nflt = 0;
   bit           zlen_cap = 1'b0;
   always #20 core_clk = ~core_clk;
   dmarfc_walker dmarfc_walker_i (.core_clk(core_clk), .resp_valid(resp_valid), .req_valid(req_valid), .req_bus(b));
   dmarfc_top dmarfc_top_i (
      .core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid), .req_is_write(b[0]), .req_zero_len(b[1]),
      .req_behind_pci_bridge(b[2]), .req_internal_err(b[3]), .rt_fetch_err(b[4]), .root_present(b[5]),
      .root_rsvd_nz(b[6]), .ct_fetch_err(b[7]), .ctx_present(b[8]), .ctx_rsvd_nz(b[9]),
      .fault_report_disable(b[10]), .table_root_fetch_err(b[11]), .pt_fetch_err(b[12]), .pte_read(b[13]),
      .pte_write(b[14]), .pte_rsvd_nz(b[15]), .domain_width_field(b[18:16]), .ctx_trans_type(b[20:19]),
      .req_addr(b[84:21]), .req_src_id(b[100:85]), .req_bridge_id(b[116:101]), .resp_valid(resp_valid),
      .resp_blocked(resp_blocked), .resp_reason(resp_reason), .resp_qualified(resp_qualified),
      .resp_report(resp_report), .resp_cpl_status(resp_cpl_status), .resp_ctx_src_id(resp_ctx_src_id),
      .resp_over_hw_width(resp_over_hw_width), .platform_err(platform_err), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic chk(input string n, input logic [63:0] v, input logic [63:0] e);
      checks++;
      if (v !== e) begin
         errors++;
         $display("unexpected %s: expected %0h seen %0h", n, e, v);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [116:0] s);
      logic [3:0] r;
      bit         q, ok;
      int         x;
      x = 39 + 9 * s[18:16];
      if (max_w < x) x = max_w;
      if (s[3]) r = FR_NONE;
      else if (s[4]) r = FR_RT_FETCH;
      else if (!s[5]) r = FR_ROOT_NP;
      else if (s[6]) r = FR_ROOT_RSVD;
      else if (s[7]) r = FR_CT_FETCH;
      else if (!s[8]) r = FR_CTX_NP;
      else if (s[9]) r = FR_CTX_RSVD;
      else if (s[18:16] > 1 || s[20:19] != 0 || s[11]) r = FR_CTX_BADPROG;
      else if ((s[84:21] >> x) != 0) r = FR_ADDR_WIDTH;
      else if (s[12]) r = FR_PT_FETCH;
      else if ((s[13] || s[14]) && s[15]) r = FR_PT_RSVD;
      else if (s[0] && !s[14]) r = FR_WRITE_PERM;
      else if (!s[0] && !s[13] && !(zlen_cap && s[1] && s[14])) r = FR_READ_PERM;
      else r = FR_NONE;
      q = r inside {[2:7], 11, 12};
      if (r != FR_NONE) begin
         nflt++;
         lsrc  = s[2] ? s[116:101] : s[100:85];
         laddr = s[52:21];
      end
      dmarfc_walker_i.send(s, rnd() % 3, 8, ok);
      chk("answer", ok, 1);
      chk("reason", resp_reason, r);
      chk("blocked", resp_blocked, r != 0 || s[3]);
      chk("qualified", resp_qualified, q);
      chk("report", resp_report, r != 0 && (!q || !s[10]));
      chk("platform", platform_err, s[3]);
      chk("over width", resp_over_hw_width, (s[84:21] >> max_w) != 0);
      chk("source", resp_ctx_src_id, s[2] ? s[116:101] : s[100:85]);
      if (!s[3]) chk("status", resp_cpl_status, (r != 0 && !s[0]) ? CPL_UR : CPL_SC);
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      give_verdict();
   end
   initial begin
      logic [31:0]  d;
      logic         e;
      logic [116:0] s;
      bit           ok;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      apb(0, REG_CTRL, 0, d, e);
      chk("ctrl", d, CTRL_RST);
      apb(0, REG_CAP, 0, d, e);
      chk("cap", d, SGAW_RST);
      apb(1, 12'h100, 32'h1, d, e);
      chk("unmapped", {e, d}, 33'h1_0000_0000);
      $display("test registers done");
      for (int k = 0; k < 16; k++) begin
         s = 117'h16120 | (117'(k % 2) << 10);
         case (k)
            0: s[4] = 1'b1;
            1: s[5] = 1'b0;
            2: s[6] = 1'b1;
            3: s[7] = 1'b1;
            4: s[8] = 1'b0;
            5: s[9] = 1'b1;
            6: s[19] = 1'b1;
            7: s[69] = 1'b1;
            8: s[12] = 1'b1;
            9: s[15] = 1'b1;
            10: s = s ^ 117'h4001;
            11: s[13] = 1'b0;
            12: s[3] = 1'b1;
            13: s[17:16] = 2'b10;
            14: s[11] = 1'b1;
            default: s[6:4] = 3'b001;
         endcase
         run(s);
      end
      apb(0, REG_FAULT, 0, d, e);
      chk("fault reg", {d[31], d[3:0]}, {1'b1, FR_RT_FETCH});
      apb(1, REG_FAULT, 32'h8000_0000, d, e);
      apb(0, REG_FAULT, 0, d, e);
      chk("fault clear", d[31], 0);
      $display("test directed done");
      // with enable clear a held request must go unanswered for 6 cycles
      apb(1, REG_CTRL, 32'h3000, d, e);
      dmarfc_walker_i.send(117'h16120, 0, 6, ok);
      chk("disabled", ok, 0);
      apb(1, REG_CTRL, 32'h2803, d, e);
      apb(0, REG_CTRL, 0, d, e);
      chk("ctrl wr", d, 32'h2803);
      zlen_cap = 1'b1;
      max_w = 40;
      run(117'h14122);
      repeat (300) begin
         s[15:0] = 16'(rnd() & rnd() & rnd() ^ 32'h6120 | rnd() & 32'h0407);
         s[18:16] = 3'(rnd() % 3);
         s[20:19] = 2'(rnd() & rnd() & rnd());
         s[84:21] = 64'({rnd(), rnd()} >> (rnd() % 16 + 20));
         s[116:85] = 32'(rnd());
         if (s[2]) s[108:101] = 8'h00;
         run(s);
      end
      apb(0, REG_COUNT, 0, d, e);
      chk("count", d, nflt);
      apb(0, REG_SRCID, 0, d, e);
      chk("last src", d, lsrc);
      apb(0, REG_ADDR_LO, 0, d, e);
      chk("last addr", d, laddr);
      $display("test random done");
      give_verdict();
   end
endmodule
